/* hdl/ilk_apb_regs.v */
`timescale 1ns/1ns
`include "ilk_defines.vh"
// ***************************************************************
// apb slave holding configuration and reporting state
// ***************************************************************
module ilk_apb_regs (
   input  wire        core_clk,      // system clock
   input  wire        srst,          // synchronous reset
   input  wire        psel,          // apb select
   input  wire        penable,       // apb enable
   input  wire        pwrite,        // apb direction
   input  wire [11:0] paddr,         // apb byte address
   input  wire [31:0] pwdata,        // apb write data
   output reg  [31:0] prdata,        // apb read data
   output wire        pready,        // apb ready
   output wire        pslverr,       // apb error
   input  wire [15:0] cond,          // condition flags
   input  wire [15:0] first_out,     // first-out flags
   input  wire [15:0] bypassed,      // bypassed flags
   input  wire [3:0]  status,        // summary status
   output reg  [15:0] ok_state_q,    // healthy levels
   output reg  [15:0] latch_cfg_q,   // latching inputs
   output reg  [15:0] byp_cfg_q,     // bypass permitted
   output reg  [15:0] maint_bypass_select_q, // maintenance bypass select
   output reg         reset_cmd_q    // reset command pulse
);
   wire wr_en;
   wire rd_en;
   reg  hit;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite; // load in setup, stands through access
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // address decode for the error response
   always @* begin
      hit = 1'b1;
      case (paddr)
         `ILK_OFS_OK_STATE, `ILK_OFS_LATCH_CFG, `ILK_OFS_BYP_CFG, `ILK_OFS_MAINT_BYP,
         `ILK_OFS_CMD, `ILK_OFS_COND, `ILK_OFS_FIRST_OUT, `ILK_OFS_BYPASSED,
         `ILK_OFS_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // write lands at the access edge; read data is valid while pready is high
   always @(posedge core_clk) begin
      if (srst) begin
         ok_state_q            <= `ILK_RST_OK_STATE;
         latch_cfg_q           <= `ILK_RST_CFG;
         byp_cfg_q             <= `ILK_RST_CFG;
         maint_bypass_select_q <= `ILK_RST_CFG;
         reset_cmd_q           <= 1'b0;
         prdata                <= 32'h00000000;
      end else begin
         reset_cmd_q <= 1'b0;
         if (wr_en) begin
            case (paddr)
               `ILK_OFS_OK_STATE:  ok_state_q            <= pwdata[15:0];
               `ILK_OFS_LATCH_CFG: latch_cfg_q           <= pwdata[15:0];
               `ILK_OFS_BYP_CFG:   byp_cfg_q             <= pwdata[15:0];
               `ILK_OFS_MAINT_BYP: maint_bypass_select_q <= pwdata[15:0];
               `ILK_OFS_CMD:       reset_cmd_q <= pwdata[`ILK_CMD_RESET_BIT];
               default:            reset_cmd_q <= 1'b0;
            endcase
         end
         if (rd_en) begin
            case (paddr)
               `ILK_OFS_OK_STATE:  prdata <= {16'h0000, ok_state_q};
               `ILK_OFS_LATCH_CFG: prdata <= {16'h0000, latch_cfg_q};
               `ILK_OFS_BYP_CFG:   prdata <= {16'h0000, byp_cfg_q};
               `ILK_OFS_MAINT_BYP: prdata <= {16'h0000, maint_bypass_select_q};
               `ILK_OFS_COND:      prdata <= {16'h0000, cond};
               `ILK_OFS_FIRST_OUT: prdata <= {16'h0000, first_out};
               `ILK_OFS_BYPASSED:  prdata <= {16'h0000, bypassed};
               `ILK_OFS_STATUS:    prdata <= {28'h0000000, status};
               default:            prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // ilk_apb_regs

/* hdl/ilk_channel.v */
`timescale 1ns/1ns
// ***************************************************************
// one condition channel: healthy check, bypass, latch
// ***************************************************************
module ilk_channel (
   input  wire core_clk,    // system clock
   input  wire srst,        // synchronous reset
   input  wire scan,        // evaluation strobe
   input  wire inp,         // condition input
   input  wire ok_level,    // configured healthy level
   input  wire latch_en,    // configured latching
   input  wire byp_ok,      // bypass permitted
   input  wire byp_sel,     // maintenance bypass selected
   input  wire byp_enabled, // downstream bypass enabled
   input  wire defeat,      // effective latch defeat
   input  wire reset_cmd,   // reset command
   output reg  cond_q,      // interlock condition
   output wire not_ok,      // input off healthy level
   output wire bypassed     // input presently bypassed
);
   wire raise;
   assign not_ok   = (inp != ok_level);
   assign bypassed = byp_ok & byp_sel & byp_enabled;
   assign raise    = not_ok & ~bypassed;

   // condition flop, updated only on a scan
   always @(posedge core_clk) begin
      if (srst) begin
         cond_q <= 1'b0;
      end else if (scan) begin
         if (raise) begin
            cond_q <= 1'b1;
         end else if (!latch_en || defeat) begin
            cond_q <= 1'b0;
         end else if (reset_cmd) begin
            cond_q <= 1'b0;
         end
      end
   end
endmodule // ilk_channel

/* hdl/ilk_concentrator.v */
`timescale 1ns/1ns
`include "ilk_defines.vh"
// Overview of operation
// - compare each input with its healthy level
// - latching inputs hold condition until reset
// - non-latching conditions clear when input healthy
// - suppress only when all three bypass bits
// - first raised condition from clear is first-out
// - simultaneous first conditions all marked first-out
// - latch defeat ignores latching configuration
// - defeat ignored until prior latches reset
// - all-clear true only with no conditions
// - nonbypassable clear counts bypassed as clear
// - report condition and bypass per input
// - disabled: summaries low, condition and first-out flags held
// - latch and first-out kept across stop/run
// - commands before first scan discarded
// - no alarm outputs generated
module ilk_concentrator (
   input  wire        core_clk,             // 20 mhz clock, one scan per enabled cycle
   input  wire        srst,                 // synchronous reset
   input  wire        scan_enable_in,       // evaluation enable
   input  wire [15:0] cond_in,              // condition inputs
   input  wire        bypass_enabled_in,    // downstream bypass enabled
   input  wire        latch_defeat_in,      // latch defeat request
   input  wire        reset_in,             // reset command pulse from logic
   input  wire        psel,                 // apb select
   input  wire        penable,              // apb enable
   input  wire        pwrite,               // apb direction
   input  wire [11:0] paddr,                // apb address
   input  wire [31:0] pwdata,               // apb write data
   output wire [31:0] prdata,               // apb read data
   output wire        pready,               // apb ready
   output wire        pslverr,              // apb error
   output reg         all_conditions_clear, // no condition at all
   output reg         nonbypassable_clear,  // clear counting bypass
   output wire [15:0] cond_out,             // per-input condition
   output wire [15:0] first_out,            // per-input first-out
   output reg  [15:0] bypassed_out          // per-input bypassed
);
   // ***************************************************************
   // internal signals
   // ***************************************************************
   wire [15:0] ok_state;
   wire [15:0] latch_cfg;
   wire [15:0] byp_cfg;
   wire [15:0] maint_bypass_select;
   wire        reg_reset_cmd;
   wire [15:0] cond_q;
   wire [15:0] not_ok;
   wire [15:0] byp_now;
   reg  [15:0] first_out_q;
   reg  [15:0] held_q;      // latches caught while defeat was off
   reg         scanned_q;
   wire        scan;
   wire        reset_cmd;
   wire        defeat;
   wire [3:0]  status;
   wire [15:0] nb_fault;

   // scan runs every enabled clock
   assign scan      = scan_enable_in;
   // commands before first evaluation are dropped
   assign reset_cmd = scanned_q & (reset_in | reg_reset_cmd);
   // defeat acts only once no held latch remains
   assign defeat    = latch_defeat_in & ~(|held_q);

   // ***************************************************************
   // register file
   // ***************************************************************
   ilk_apb_regs u_regs (
      .core_clk              (core_clk),
      .srst                  (srst),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .cond                  (cond_q),
      .first_out             (first_out_q),
      .bypassed              (bypassed_out),
      .status                (status),
      .ok_state_q            (ok_state),
      .latch_cfg_q           (latch_cfg),
      .byp_cfg_q             (byp_cfg),
      .maint_bypass_select_q (maint_bypass_select),
      .reset_cmd_q           (reg_reset_cmd)
   );

   // ***************************************************************
   // channels
   // ***************************************************************
   genvar i;
   generate
      for (i = 0; i < `ILK_NUM_CH; i = i + 1) begin : g_ch
         // compare, bypass and latch per input
         ilk_channel u_ch (
            .core_clk    (core_clk),
            .srst        (srst),
            .scan        (scan),
            .inp         (cond_in[i]),
            .ok_level    (ok_state[i]),
            .latch_en    (latch_cfg[i]),
            .byp_ok      (byp_cfg[i]),
            .byp_sel     (maint_bypass_select[i]),
            .byp_enabled (bypass_enabled_in),
            .defeat      (defeat),
            .reset_cmd   (reset_cmd),
            .cond_q      (cond_q[i]),
            .not_ok      (not_ok[i]),
            .bypassed    (byp_now[i])
         );
         assign nb_fault[i] = not_ok[i] & ~byp_now[i];
      end
   endgenerate

   // ***************************************************************
   // first-out, held latches, scan flag
   // ***************************************************************
   // first-out captured from the clear state; only srst and reset commands clear state,
   // nothing is lost on an enable drop
   always @(posedge core_clk) begin
      if (srst) begin
         first_out_q <= 16'h0000;
         held_q      <= 16'h0000;
         scanned_q   <= 1'b0;
      end else if (scan) begin
         scanned_q <= 1'b1;
         // an idle clear scan keeps the old first-out until a reset pulse
         if ((cond_q == 16'h0000) && (nb_fault != 16'h0000)) begin
            first_out_q <= nb_fault;
         end else if (reset_cmd && (nb_fault == 16'h0000)) begin
            first_out_q <= 16'h0000;
         end
         // latches that trip while defeat is off are tracked until reset
         held_q <= (held_q | (nb_fault & latch_cfg & {16{~latch_defeat_in}}))
                   & ~({16{reset_cmd}} & ~nb_fault);
      end
   end

   // ***************************************************************
   // summaries, no alarm outputs exist
   // ***************************************************************
   always @(posedge core_clk) begin
      if (srst) begin
         all_conditions_clear <= 1'b0;
         nonbypassable_clear  <= 1'b0;
         bypassed_out         <= 16'h0000;
      end else begin
         bypassed_out <= byp_now;
         if (!scan_enable_in) begin
            all_conditions_clear <= 1'b0;
            nonbypassable_clear  <= 1'b0;
         end else begin
            all_conditions_clear <= ~(|(cond_q | not_ok));
            nonbypassable_clear  <= ~(|(cond_q & ~byp_now)) & ~(|nb_fault);
         end
      end
   end

   assign cond_out  = cond_q;
   assign first_out = first_out_q;
   assign status    = {scanned_q, |held_q & latch_defeat_in,
                       nonbypassable_clear, all_conditions_clear};
endmodule // ilk_concentrator

/* hdl/ilk_defines.vh */
`ifndef ILK_DEFINES_VH
`define ILK_DEFINES_VH
// ***************************************************************
// channel count and apb register map
// ***************************************************************
`define ILK_NUM_CH        16
`define ILK_OFS_OK_STATE  12'h000
`define ILK_OFS_LATCH_CFG 12'h004
`define ILK_OFS_BYP_CFG   12'h008
`define ILK_OFS_MAINT_BYP 12'h00c
`define ILK_OFS_CMD       12'h010
`define ILK_OFS_COND      12'h014
`define ILK_OFS_FIRST_OUT 12'h018
`define ILK_OFS_BYPASSED  12'h01c
`define ILK_OFS_STATUS    12'h020
// ***************************************************************
// field positions and reset values
// ***************************************************************
`define ILK_CMD_RESET_BIT 0
`define ILK_ST_ALL_CLEAR  0
`define ILK_ST_NB_CLEAR   1
`define ILK_ST_DEFEAT_ACT 2
`define ILK_ST_SCANNED    3
`define ILK_RST_OK_STATE  16'h0000
`define ILK_RST_CFG       16'h0000
`endif

/* test/ilk_checker.sv */
`timescale 1ns/1ns
// ***************************************************************
// port relations of the concentrator
// ***************************************************************
module ilk_checker (
   input wire        core_clk,             // clock
   input wire        srst,                 // reset
   input wire        scan_enable_in,       // scan enable
   input wire        bypass_enabled_in,    // bypass status
   input wire        psel,                 // apb select
   input wire        penable,              // apb enable
   input wire [11:0] paddr,                // apb address
   input wire        pslverr,              // apb error
   input wire        all_conditions_clear, // summary
   input wire        nonbypassable_clear,  // summary
   input wire [15:0] cond_out,             // conditions
   input wire [15:0] first_out,            // first-out flags
   input wire [15:0] bypassed_out          // bypassed flags
);
   // one clock domain, reset disables all but the reset check
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_dis; !scan_enable_in |=> !all_conditions_clear && !nonbypassable_clear; endproperty
   a_dis: assert property (p_dis) else $error("summary high while disabled");
   property p_hold; !scan_enable_in |=> $stable(cond_out) && $stable(first_out); endproperty
   a_hold: assert property (p_hold) else $error("flags moved while disabled");
   property p_all; cond_out != 16'h0000 |=> !all_conditions_clear; endproperty
   a_all: assert property (p_all) else $error("all clear with a condition");
   // a latched condition may be bypassed later, so only check with bypass off
   property p_nb;
      cond_out != 16'h0000 && !bypass_enabled_in |=> !nonbypassable_clear;
   endproperty
   a_nb: assert property (p_nb) else $error("nb clear with a condition");
   property p_sub; all_conditions_clear |-> nonbypassable_clear; endproperty
   a_sub: assert property (p_sub) else $error("all clear without nb clear");
   property p_byp; scan_enable_in && !bypass_enabled_in |=> bypassed_out == 16'h0000; endproperty
   a_byp: assert property (p_byp) else $error("bypassed without enable");
   property p_err; psel && penable && paddr > 12'h020 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_rst;
      disable iff (1'b0) srst |=> cond_out == 16'h0000 && first_out == 16'h0000;
   endproperty
   a_rst: assert property (p_rst) else $error("flags not cleared by reset");
endmodule // ilk_checker

bind ilk_concentrator ilk_checker i_chk (.core_clk(core_clk), .srst(srst),
   .scan_enable_in(scan_enable_in), .bypass_enabled_in(bypass_enabled_in), .psel(psel),
   .penable(penable), .paddr(paddr), .pslverr(pslverr), .cond_out(cond_out),
   .all_conditions_clear(all_conditions_clear), .nonbypassable_clear(nonbypassable_clear),
   .first_out(first_out), .bypassed_out(bypassed_out));

/* test/ilk_equip_model.sv */
`timescale 1ns/1ns
// ***************************************************************
// downstream equipment controller
// ***************************************************************
module ilk_equip_model (
   input  wire core_clk,            // clock
   input  wire srst,                // reset
   input  wire start_req,           // operator start
   input  wire byp_req,             // operator bypass request
   input  wire nonbypassable_clear, // run permit from block
   output reg  bypass_enabled_in,   // bypass status to block
   output wire latch_defeat_in      // defeat while stopped
);
   reg running_q;
   // runs only while permitted, so a trip stops it one edge after the permit drops
   always @(posedge core_clk) begin
      running_q <= !srst && start_req && nonbypassable_clear;
      bypass_enabled_in <= !srst && byp_req;
   end
   assign latch_defeat_in = !running_q;
endmodule // ilk_equip_model

/* test/tb_top.sv */
`timescale 1ns/1ns
`include "ilk_defines.vh"
// ***************************************************************
// concentrator bench
// ***************************************************************
module tb_top;
   localparam [63:0] CFG = 64'h0308_0f00_0003_00f0; // maint, bypass, latch, healthy
   reg         core_clk, srst, scan_enable_in, reset_in, start_req, byp_req, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [15:0] cond_in;
   reg         err;
   wire [31:0] prdata;
   wire        pready, pslverr, all_conditions_clear, nonbypassable_clear;
   wire        bypass_enabled_in, latch_defeat_in;
   wire [15:0] cond_out, first_out, bypassed_out;
   integer     n_mismatch, tests_run, i;
   ilk_concentrator i_dut (.core_clk(core_clk), .srst(srst), .scan_enable_in(scan_enable_in),
      .cond_in(cond_in), .bypass_enabled_in(bypass_enabled_in), .latch_defeat_in(latch_defeat_in),
      .reset_in(reset_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .all_conditions_clear(all_conditions_clear), .nonbypassable_clear(nonbypassable_clear),
      .cond_out(cond_out), .first_out(first_out), .bypassed_out(bypassed_out));
   ilk_equip_model i_equip (.core_clk(core_clk), .srst(srst), .start_req(start_req),
      .byp_req(byp_req), .nonbypassable_clear(nonbypassable_clear),
      .bypass_enabled_in(bypass_enabled_in), .latch_defeat_in(latch_defeat_in));
   // clock at 20 mhz
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk16(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // apb transfer; response and read data taken at the edge where pready is high
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge core_clk);
         penable <= 1'b1;
         @(posedge core_clk);
         while (pready !== 1'b1) @(posedge core_clk);
         err = pslverr;
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
         // one idle edge so a following call never re-raises psel in this step
         @(posedge core_clk);
      end
   endtask
   // new input levels, then conditions, first-out and summaries
   task ev(input [15:0] c, input [15:0] ec, input [15:0] ef, input [1:0] es);
      begin
         cond_in <= c;
         tick(3);
         chk16("cond", ec, cond_out);
         chk16("first", ef, first_out);
         chk16("summary", {14'h0, es}, {14'h0, all_conditions_clear, nonbypassable_clear});
      end
   endtask
   task pulse;
      begin
         reset_in <= 1'b1;
         tick(1);
         reset_in <= 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   // watchdog against a hang
   initial begin
      tick(4000);
      n_mismatch = n_mismatch + 1;
      final_report;
   end
   // main sequence
   initial begin
      srst = 1'b1;
      scan_enable_in = 1'b1;
      cond_in = 16'h0;
      reset_in = 1'b0;
      start_req = 1'b0;
      byp_req = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      n_mismatch = 0;
      tests_run = 0;
      tick(4);
      srst <= 1'b0;
      tick(2);
      for (i = 0; i < 4; i = i + 1) apb(1'b1, 4 * i, {16'h0, CFG[16 * i +: 16]});
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b0, 4 * i, 32'h0);
         chk16("cfg", CFG[16 * i +: 16], rd[15:0]);
      end
      apb(1'b0, 12'h040, 32'h0);
      chk16("unmapped", 16'h8000, {err, rd[14:0]});
      $display("test registers done");
      ev(16'h0000, 16'h00f0, 16'h00f0, 2'b00);
      ev(16'h00f0, 16'h0000, 16'h00f0, 2'b11);
      apb(1'b1, `ILK_OFS_CMD, 32'h1);
      ev(16'h00f0, 16'h0000, 16'h0000, 2'b11);
      apb(1'b0, `ILK_OFS_STATUS, 32'h0);
      chk16("scanned", 16'h0001, {15'h0, rd[`ILK_ST_SCANNED]});
      ev(16'h00f4, 16'h0004, 16'h0004, 2'b00);
      ev(16'h00d4, 16'h0024, 16'h0004, 2'b00);
      ev(16'h00f0, 16'h0000, 16'h0004, 2'b11);
      pulse;
      $display("test first-out done");
      byp_req <= 1'b1;
      // the controller reports bypass one edge later; let it settle first
      tick(2);
      ev(16'h05f8, 16'h0408, 16'h0408, 2'b00);
      chk16("bypassed", 16'h0300, bypassed_out);
      ev(16'h01f0, 16'h0000, 16'h0408, 2'b01);
      apb(1'b1, `ILK_OFS_CMD, 32'h1);
      byp_req <= 1'b0;
      ev(16'h01f0, 16'h0100, 16'h0100, 2'b00);
      ev(16'h00f0, 16'h0000, 16'h0100, 2'b11);
      pulse;
      $display("test bypass done");
      start_req <= 1'b1;
      tick(4);
      ev(16'h00f1, 16'h0001, 16'h0001, 2'b00);
      ev(16'h00f0, 16'h0001, 16'h0001, 2'b00);
      pulse;
      ev(16'h00f0, 16'h0000, 16'h0000, 2'b11);
      start_req <= 1'b0;
      tick(4);
      ev(16'h00f2, 16'h0002, 16'h0002, 2'b00);
      ev(16'h00f0, 16'h0000, 16'h0002, 2'b11);
      $display("test latching done");
      scan_enable_in <= 1'b0;
      ev(16'h00f4, 16'h0000, 16'h0002, 2'b00);
      scan_enable_in <= 1'b1;
      ev(16'h00f0, 16'h0000, 16'h0002, 2'b11);
      $display("test enable done");
      final_report;
   end
endmodule // tb_top
